// file: include/bsr_map.vh
// Register map, field positions, reset values and timing for the baseband control block.
// Assumes a 100 MHz system clock; included by the top design file under verilog/ and by the testbench.
`ifndef BSR_MAP_VH
`define BSR_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (6-bit address space)
`define BSR_ADDR_CONTROL     6'h03
`define BSR_ADDR_DATA_RATE   6'h04
`define BSR_ADDR_RX_DATA     6'h09
`define BSR_ADDR_TX_STATUS   6'h0E
`define BSR_ADDR_TX_DATA     6'h0F
`define BSR_ADDR_SIG_STR     6'h22
`define BSR_ADDR_CD_FORCE    6'h2F

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define BSR_CTL_RX_EN_BIT    7
`define BSR_CTL_TX_EN_BIT    6
`define BSR_CTL_PA_MSB       2
`define BSR_CTL_PA_LSB       0
`define BSR_RATE_MSB         1
`define BSR_RATE_LSB         0
`define BSR_SIG_VAL_MSB      4
`define BSR_SIG_VAL_LSB      0
`define BSR_SIG_VALID_BIT    5
`define BSR_CD_FORCE_BIT     7
`define BSR_STAT_READY_BIT   0
`define BSR_STAT_EMPTY_BIT   1
`define BSR_STAT_RXNEW_BIT   2

////////////////////////////////////////////////////////////////////////////////
// Spreading modes
`define BSR_MODE_64          2'h0
`define BSR_MODE_32          2'h1
`define BSR_MODE_32_DDR      2'h2
`define BSR_CHIPS_64         7'h40
`define BSR_CHIPS_32         7'h20

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define BSR_RST_CONTROL      8'h00
`define BSR_RST_DATA_RATE    2'h0
`define BSR_RST_CD_FORCE     1'h0
`define BSR_RST_SIG_STR      5'h00

////////////////////////////////////////////////////////////////////////////////
// Timing
`define BSR_CLK_NS           10
`define BSR_CHIP_NS          1000
`define BSR_CHIP_CYC         (`BSR_CHIP_NS / `BSR_CLK_NS)
`define BSR_SIGNAL_STRENGTH_RESULT_WAIT_NS     50000
`define BSR_SIGNAL_STRENGTH_RESULT_WAIT_CYC    (`BSR_SIGNAL_STRENGTH_RESULT_WAIT_NS / `BSR_CLK_NS)
`define BSR_CONV_CYC         16

`endif

// file: verilog/bsr_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`default_nettype none

module bsr_fifo #(
  parameter W  = 8,
  parameter D  = 32,
  parameter AW = 5
) (
  // Clock and reset
  input  wire          clk_sys,
  input  wire          rst_n,
  // Fill side
  input  wire          in_valid,
  input  wire [W-1:0]  in_data,
  output wire          in_ready,
  // Drain side
  output wire          out_valid,
  output wire [W-1:0]  out_data,
  input  wire          out_ready,
  // Level
  output wire          empty
);

  reg  [W-1:0]  mem [0:D-1];
  reg  [AW:0]   wr_ptr_r;
  reg  [AW:0]   rd_ptr_r;
  wire          full;
  wire          push;
  wire          pop;

  // Extra pointer bit tells full from empty
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;

  always @(posedge clk_sys)
  begin
    if (push)
      mem[wr_ptr_r[AW-1:0]] <= in_data;
  end

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

endmodule

`default_nettype wire

// file: verilog/bsr_top.v
// Baseband spreader, byte serdes and signal-strength control, reached over the SPI slave port.
// Assumes clk_sys at 100 MHz, SPI pins from outside the clock domain, correlator and ADC on clk_sys.
//
// Functional notes
// - Three spreading modes exist: 64 chips/bit, 32 chips/bit, and 32 chips/bit dual data rate.
// - The 64 chips/bit mode carries one stream at 15.625 kbit/s using the longest code.
// - The 32 chips/bit single-rate mode carries one stream at 31.25 kbit/s.
// - Dual data rate spreads two payload bits per symbol for 62.5 kbit/s.
// - The spreader emits chips at 1 MHz for the modulator.
// - Transmit goes through a 32-byte buffer so the host can load the next byte while one is sent, leaving no gaps.
// - Each received byte lands in the receive data register and is overwritten by the next one.
// - In receive, a conversion starts by itself once the carrier has stayed above the floor over 50 us.
// - A finished conversion writes the 5-bit value to bits 4:0 of register 0x22 and sets bit 5 valid.
// - After a conversion the machine halts until receive mode is switched off and on.
// - Setting bit 7 of register 0x2F while receiving forces a conversion.
// - The amplifier setting accepts 0 to 7, with 7 the highest power.
`include "bsr_map.vh"
`default_nettype none

module bsr_top #(
  parameter         SIGNAL_STRENGTH_RESULT_WAIT_CYC = `BSR_SIGNAL_STRENGTH_RESULT_WAIT_CYC,
  parameter         CONV_CYC      = `BSR_CONV_CYC,
  parameter         FIFO_DEPTH    = 32,
  parameter         FIFO_AW       = 5,
  parameter [63:0]  PN_CODE       = 64'hA5C3_96F0_3C5A_0FE1
) (
  // Clock and reset
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire         power_down_n,
  // SPI slave pins
  input  wire         spi_sck,
  input  wire         spi_mosi,
  input  wire         spi_ss_n,
  output wire         spi_miso_o,
  output wire         spi_miso_oe_n,
  // Spreader output
  output wire         tx_chip,
  output wire         tx_chip_strobe,
  output wire         tx_active,
  output wire         tx_fifo_ready,
  output wire [2:0]   pa_level,
  output wire [1:0]   rate_mode,
  // Correlator input
  output wire         rx_enable,
  input  wire         rx_bit,
  input  wire         rx_bit_strobe,
  // Signal strength converter
  input  wire         carrier_above_floor,
  input  wire [4:0]   adc_value,
  output wire         adc_start
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: sck, mosi, ss_n, power_down_n, carrier
  reg  [4:0]  sync1_r;
  reg  [4:0]  sync2_r;
  reg         sck_d_r;
  wire        sck_s   = sync2_r[0];
  wire        mosi_s  = sync2_r[1];
  wire        ss_n_s  = sync2_r[2];
  wire        pd_n_s  = sync2_r[3];
  wire        carr_s  = sync2_r[4];
  wire        sck_rise = sck_s && !sck_d_r;
  wire        sck_fall = !sck_s && sck_d_r;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_r <= 5'h04;
      sync2_r <= 5'h04;
      sck_d_r <= 1'b0;
    end
    else
    begin
      sync1_r <= {carrier_above_floor, power_down_n, spi_ss_n, spi_mosi, spi_sck};
      sync2_r <= sync1_r;
      sck_d_r <= sck_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and shared state
  reg  [7:0]  ctrl_r;
  reg  [1:0]  rate_r;
  reg         cd_force_r;
  reg  [4:0]  sig_val_r;
  reg         sig_valid_r;
  reg  [7:0]  rx_data_r;
  reg         rx_new_r;
  wire        fifo_empty;
  wire        fifo_in_ready;
  wire        rx_on = ctrl_r[`BSR_CTL_RX_EN_BIT] && pd_n_s;
  wire        tx_on = ctrl_r[`BSR_CTL_TX_EN_BIT] && pd_n_s;

  // Read decode, used for the command byte and every burst byte
  function [7:0] rd_mux;
    input [5:0] a;
    begin
      case (a)
        `BSR_ADDR_CONTROL:   rd_mux = ctrl_r;
        `BSR_ADDR_DATA_RATE: rd_mux = {6'h00, rate_r};
        `BSR_ADDR_RX_DATA:   rd_mux = rx_data_r;
        `BSR_ADDR_TX_STATUS: rd_mux = {5'h00, rx_new_r, fifo_empty, fifo_in_ready};
        `BSR_ADDR_SIG_STR:   rd_mux = {2'h0, sig_valid_r, sig_val_r};
        `BSR_ADDR_CD_FORCE:  rd_mux = {cd_force_r, 7'h00};
        default:             rd_mux = 8'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // SPI slave: command byte then burst of data bytes, MSB first
  reg  [7:0]  sh_in_r;
  reg  [2:0]  bitc_r;
  reg         first_r;
  reg         dir_wr_r;
  reg         inc_r;
  reg  [5:0]  addr_r;
  reg  [7:0]  sh_out_r;
  wire [7:0]  byte_in   = {sh_in_r[6:0], mosi_s};
  wire        byte_done = !ss_n_s && sck_rise && (bitc_r == 3'h7);
  wire        data_byte = byte_done && !first_r;
  wire        wr_stb    = data_byte && dir_wr_r;
  wire [5:0]  addr_nxt  = first_r ? byte_in[5:0] : (inc_r ? addr_r + 6'h01 : addr_r);
  wire        tx_push   = wr_stb && (addr_r == `BSR_ADDR_TX_DATA);
  wire        rx_read   = byte_done && !(first_r ? byte_in[7] : dir_wr_r) && (addr_nxt == `BSR_ADDR_RX_DATA);

  assign spi_miso_o    = sh_out_r[7];
  assign spi_miso_oe_n = ss_n_s;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_in_r  <= 8'h00;
      bitc_r   <= 3'h0;
      first_r  <= 1'b1;
      dir_wr_r <= 1'b0;
      inc_r    <= 1'b0;
      addr_r   <= 6'h00;
      sh_out_r <= 8'h00;
    end
    else if (ss_n_s)
    begin
      bitc_r  <= 3'h0;
      first_r <= 1'b1;
    end
    else if (sck_rise)
    begin
      sh_in_r <= byte_in;
      bitc_r  <= bitc_r + 3'h1;
      if (bitc_r == 3'h7)
      begin
        if (first_r)
        begin
          dir_wr_r <= byte_in[7];
          inc_r    <= byte_in[6];
        end
        first_r  <= 1'b0;
        addr_r   <= addr_nxt;
        sh_out_r <= rd_mux(addr_nxt);
      end
    end
    // No shift right after a load, so the MSB is presented first
    else if (sck_fall && (bitc_r != 3'h0))
      sh_out_r <= {sh_out_r[6:0], 1'b0};
  end

  // Writable registers
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r     <= `BSR_RST_CONTROL;
      rate_r     <= `BSR_RST_DATA_RATE;
      cd_force_r <= `BSR_RST_CD_FORCE;
    end
    else if (wr_stb)
    begin
      if (addr_r == `BSR_ADDR_CONTROL)
        ctrl_r <= byte_in;
      if (addr_r == `BSR_ADDR_DATA_RATE)
        rate_r <= (byte_in[1:0] == 2'h3) ? `BSR_MODE_64 : byte_in[1:0];
      if (addr_r == `BSR_ADDR_CD_FORCE)
        cd_force_r <= byte_in[`BSR_CD_FORCE_BIT];
    end
  end

  assign pa_level  = ctrl_r[`BSR_CTL_PA_MSB:`BSR_CTL_PA_LSB];
  assign rate_mode = rate_r;
  assign rx_enable = rx_on;

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit byte buffer: a full buffer drops the write, visible in the status register
  wire        fifo_out_valid;
  wire [7:0]  fifo_out_data;
  wire        fifo_pop;

  bsr_fifo #(
    .W  (8),
    .D  (FIFO_DEPTH),
    .AW (FIFO_AW)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (tx_push),
    .in_data   (byte_in),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (fifo_pop),
    .empty     (fifo_empty)
  );

  assign tx_fifo_ready = fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // Serializer and spreader, LSB first
  reg         tx_busy_r;
  reg  [7:0]  tx_sh_r;
  reg  [3:0]  bits_left_r;
  reg  [5:0]  chip_idx_r;
  reg  [6:0]  div_r;
  reg         chip_r;
  reg         chip_stb_r;
  wire        ddr       = (rate_r == `BSR_MODE_32_DDR);
  wire [6:0]  chips_sym = (rate_r == `BSR_MODE_64) ? `BSR_CHIPS_64 : `BSR_CHIPS_32;
  wire [3:0]  bits_sym  = ddr ? 4'h2 : 4'h1;
  wire        chip_tick = tx_busy_r && (div_r == (`BSR_CHIP_CYC - 1));
  wire        sym_end   = chip_tick && ({1'b0, chip_idx_r} == chips_sym - 7'h01);
  wire        byte_end  = sym_end && (bits_left_r == bits_sym);
  wire        chip_nxt  = PN_CODE[chip_idx_r] ^ tx_sh_r[0] ^ (ddr & tx_sh_r[1] & chip_idx_r[0]);

  // Next byte is taken in the same cycle the last symbol ends
  assign fifo_pop = tx_on && fifo_out_valid && (!tx_busy_r || byte_end);

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_busy_r   <= 1'b0;
      tx_sh_r     <= 8'h00;
      bits_left_r <= 4'h0;
      chip_idx_r  <= 6'h00;
      div_r       <= 7'h00;
      chip_r      <= 1'b0;
      chip_stb_r  <= 1'b0;
    end
    else
    begin
      chip_stb_r <= chip_tick;
      if (chip_tick)
        chip_r <= chip_nxt;
      if (fifo_pop)
      begin
        tx_busy_r   <= 1'b1;
        tx_sh_r     <= fifo_out_data;
        bits_left_r <= 4'h8;
        chip_idx_r  <= 6'h00;
        div_r       <= 7'h00;
      end
      else if (!tx_on || byte_end)
        tx_busy_r <= 1'b0;
      else if (tx_busy_r)
      begin
        div_r <= chip_tick ? 7'h00 : div_r + 7'h01;
        if (sym_end)
        begin
          chip_idx_r  <= 6'h00;
          tx_sh_r     <= ddr ? {2'h0, tx_sh_r[7:2]} : {1'b0, tx_sh_r[7:1]};
          bits_left_r <= bits_left_r - bits_sym;
        end
        else if (chip_tick)
          chip_idx_r <= chip_idx_r + 6'h01;
      end
    end
  end

  assign tx_chip        = chip_r;
  assign tx_chip_strobe = chip_stb_r;
  assign tx_active      = tx_busy_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Deserializer: no hold-off, a new byte overwrites an unread one
  reg  [7:0]  rx_sh_r;
  reg  [2:0]  rx_cnt_r;
  wire        rx_take = rx_on && rx_bit_strobe;
  wire        rx_full = rx_take && (rx_cnt_r == 3'h7);

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_sh_r   <= 8'h00;
      rx_cnt_r  <= 3'h0;
      rx_data_r <= 8'h00;
      rx_new_r  <= 1'b0;
    end
    else
    begin
      if (!rx_on)
        rx_cnt_r <= 3'h0;
      else if (rx_take)
      begin
        rx_sh_r  <= {rx_bit, rx_sh_r[7:1]};
        rx_cnt_r <= rx_cnt_r + 3'h1;
      end
      if (rx_full)
        rx_data_r <= {rx_bit, rx_sh_r[7:1]};
      // Arrival wins over a read in the same cycle
      if (rx_full)
        rx_new_r <= 1'b1;
      else if (rx_read)
        rx_new_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Signal-strength conversion control
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_WAIT = 4'b0010;
  localparam [3:0] ST_CONV = 4'b0100;
  localparam [3:0] ST_HALT = 4'b1000;

  reg  [3:0]  st_r;
  reg  [31:0] cnt_r;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r        <= ST_IDLE;
      cnt_r       <= 32'h0;
      sig_val_r   <= `BSR_RST_SIG_STR;
      sig_valid_r <= 1'b0;
    end
    else if (!rx_on)
    begin
      st_r        <= ST_IDLE;
      cnt_r       <= 32'h0;
      sig_valid_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          st_r  <= ST_WAIT;
          cnt_r <= 32'h0;
        end
        ST_WAIT:
        begin
          if (cd_force_r)
          begin
            st_r  <= ST_CONV;
            cnt_r <= 32'h0;
          end
          else if (!carr_s)
            cnt_r <= 32'h0;
          // Strictly longer than the wait time
          else if (cnt_r >= SIGNAL_STRENGTH_RESULT_WAIT_CYC)
          begin
            st_r  <= ST_CONV;
            cnt_r <= 32'h0;
          end
          else
            cnt_r <= cnt_r + 32'h1;
        end
        ST_CONV:
        begin
          if (cnt_r >= CONV_CYC - 1)
          begin
            sig_val_r   <= adc_value;
            sig_valid_r <= 1'b1;
            st_r        <= ST_HALT;
          end
          else
            cnt_r <= cnt_r + 32'h1;
        end
        ST_HALT:
          st_r <= ST_HALT;
        default:
          st_r <= ST_IDLE;
      endcase
    end
  end

  assign adc_start = (st_r == ST_CONV);

endmodule

`default_nettype wire

// file: tb/bsr_top_chk.sv
// Port assertions for bsr_top.
// Assumes binding onto bsr_top, one clock domain.
`default_nettype none
module bsr_top_chk #(
  parameter CONV_CYC = 4
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       power_down_n,
  // Watched pins
  input wire logic       spi_ss_n,
  input wire logic       tx_chip_strobe,
  input wire logic       tx_active,
  input wire logic [2:0] pa_level,
  input wire logic [1:0] rate_mode,
  input wire logic       rx_enable,
  input wire logic       adc_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] conv_len_r;
  logic       done_r;
  ////////////////////////////////////////
  // Length of each conversion, and halt memory until rx drops
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conv_len_r <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      conv_len_r <= adc_start ? conv_len_r + 8'h01 : 8'h00;
      done_r <= !rx_enable ? 1'b0 : (done_r | $fell(adc_start));
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_rate_legal: assert property (rate_mode != 2'h3)
    else $error("unused rate code");
  a_chip_spacing: assert property (tx_chip_strobe |=> (!tx_chip_strobe throughout (##98 1'b1)))
    else $error("chips closer than 100 cycles");
  a_strobe_active: assert property (tx_chip_strobe |-> $past(tx_active))
    else $error("chip while idle");
  a_conv_in_rx: assert property ($rose(adc_start) |-> rx_enable && $past(rx_enable))
    else $error("conversion outside receive");
  a_conv_len: assert property ($fell(adc_start) |-> conv_len_r == CONV_CYC)
    else $error("conversion length wrong");
  a_halt_once: assert property ($rose(adc_start) |-> !done_r)
    else $error("second conversion without rx toggle");
  a_cfg_quiet: assert property (spi_ss_n [*8] |=> $stable(pa_level) && $stable(rate_mode))
    else $error("config moved without host write");
  a_pd_rx_off: assert property (!power_down_n [*3] |-> !rx_enable && !tx_chip_strobe)
    else $error("active in power down");
  c_conv: cover property ($rose(adc_start));
  c_ddr_chip: cover property (tx_chip_strobe && rate_mode == 2'h2);
  c_rx_off: cover property ($fell(rx_enable));
endmodule
bind bsr_top bsr_top_chk #(.CONV_CYC(CONV_CYC)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .power_down_n(power_down_n), .spi_ss_n(spi_ss_n),
  .tx_chip_strobe(tx_chip_strobe), .tx_active(tx_active), .pa_level(pa_level),
  .rate_mode(rate_mode), .rx_enable(rx_enable), .adc_start(adc_start)
);
`default_nettype wire

// file: tb/bsr_spi_host.sv
// Controller model: SPI master, mode 0, command plus one data byte per frame.
// Assumes the slave syncs its pins to clk_sys; HALF is the SCK half period in cycles.
`default_nettype none
module bsr_spi_host #(
  parameter HALF = 8
) (
  // Clock
  input  wire logic clk_sys,
  // SPI pins
  output var logic  spi_sck,
  output var logic  spi_mosi,
  output var logic  spi_ss_n,
  input  wire logic spi_miso_o,
  input  wire logic spi_miso_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven line shows the opposite bit, never a lucky match
  wire logic miso_line = spi_miso_oe_n ? ~spi_miso_o : spi_miso_o;
  initial
  begin
    spi_sck = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Released data line keeps toggling
  always @(posedge clk_sys)
  begin
    if (spi_ss_n)
      spi_mosi <= ~spi_mosi;
  end
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wdat, output logic [7:0] rdat);
    logic [15:0] sh;
    sh = {cmd, wdat};
    rdat = 8'h00;
    @(posedge clk_sys);
    #1 spi_ss_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      spi_mosi = sh[i];
      repeat (HALF) @(posedge clk_sys);
      #1 spi_sck = 1'b1;
      rdat = {rdat[6:0], miso_line};
      repeat (HALF) @(posedge clk_sys);
      #1 spi_sck = 1'b0;
    end
    repeat (HALF) @(posedge clk_sys);
    #1 spi_ss_n = 1'b1;
    repeat (HALF) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for bsr_top: registers, serdes, spreader, signal strength.
// Assumes bsr_map.vh on the include path; long waits shortened by parameters.
`include "bsr_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WAIT_CYC = 20;
  // Arbitrary spreading code, chosen here so expected chips do not lean on the design default
  localparam logic [63:0] PN = 64'h3C96_5AA5_0FF0_C33C;
  logic        clk_sys, rst_n, power_down_n, rx_bit, rx_bit_strobe, carrier_above_floor;
  logic [4:0]  adc_value, v0;
  wire logic   spi_sck, spi_mosi, spi_ss_n, spi_miso_o, spi_miso_oe_n, tx_chip, tx_chip_strobe;
  wire logic   tx_active, tx_fifo_ready, rx_enable, adc_start;
  wire logic [2:0] pa_level;
  wire logic [1:0] rate_mode;
  int          error_cnt, checks, n, sum_got, sum_exp;
  logic [1:0]  md;
  logic [31:0] seed;
  logic [7:0]  rdat, b0, b1;
  bsr_top #(.SIGNAL_STRENGTH_RESULT_WAIT_CYC(WAIT_CYC), .CONV_CYC(4), .PN_CODE(PN)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .power_down_n(power_down_n), .spi_sck(spi_sck),
    .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n), .spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n),
    .tx_chip(tx_chip), .tx_chip_strobe(tx_chip_strobe), .tx_active(tx_active),
    .tx_fifo_ready(tx_fifo_ready), .pa_level(pa_level), .rate_mode(rate_mode), .rx_enable(rx_enable),
    .rx_bit(rx_bit), .rx_bit_strobe(rx_bit_strobe), .carrier_above_floor(carrier_above_floor),
    .adc_value(adc_value), .adc_start(adc_start)
  );
  bsr_spi_host u_host (.clk_sys(clk_sys), .spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_ss_n(spi_ss_n),
    .spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Chips for a run of bytes in a spreading mode
  function automatic int exp_chips(input logic [1:0] mode, input int nbytes);
    return nbytes * ((mode == `BSR_MODE_32_DDR) ? 4 : 8) * ((mode == `BSR_MODE_64) ? 64 : 32);
  endfunction
  // Chip c of a run: code bit, payload bit, and in dual rate the odd chips also carry the second bit
  function automatic logic exp_chip(input logic [1:0] mode, input logic [15:0] data, input int c);
    int cps, bps, sym, idx;
    cps = (mode == `BSR_MODE_64) ? 64 : 32;
    bps = (mode == `BSR_MODE_32_DDR) ? 2 : 1;
    sym = c / cps;
    idx = c % cps;
    return PN[idx] ^ data[sym * bps] ^ ((bps == 2) & data[sym * bps + 1] & idx[0]);
  endfunction
  // Host reading of a strength value: 0 quiet, 1 occupied, 2 strong
  function automatic logic [1:0] sig_class(input logic [4:0] v);
    return (v > 5'h1C) ? 2'h2 : ((v > 5'h0A) ? 2'h1 : 2'h0);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.xfer({2'b10, a}, d, rdat);
  endtask
  task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
    u_host.xfer({2'b00, a}, 8'h00, rdat);
    chk({8'h00, rdat}, {8'h00, e});
  endtask
  task automatic send_rx(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      #1 rx_bit = d[i];
      rx_bit_strobe = 1'b1;
      @(posedge clk_sys);
      #1 rx_bit_strobe = 1'b0;
      rx_bit = ~rx_bit;
    end
  endtask
  // Bounded wait for adc_start to reach a level
  task automatic wait_adc(input logic lvl);
    int k;
    k = 0;
    while (adc_start !== lvl && k < 2000)
    begin
      @(posedge clk_sys);
      #1 k++;
    end
    if (k == 2000)
    begin
      chk(16'h0000, 16'h0001);
      print_verdict();
    end
  endtask
  task automatic print_verdict();
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    power_down_n = 1'b1;
    rx_bit = 1'b0;
    rx_bit_strobe = 1'b0;
    carrier_above_floor = 1'b0;
    adc_value = 5'h00;
    error_cnt = 0;
    checks = 0;
    seed = 32'd38371;
    repeat (10) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({11'h000, pa_level, rate_mode}, 16'h0000);
    rdchk(`BSR_ADDR_SIG_STR, 8'h00);
    rdchk(`BSR_ADDR_CD_FORCE, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(`BSR_ADDR_DATA_RATE, 8'(m));
      rdchk(`BSR_ADDR_DATA_RATE, (m == 3) ? 8'h00 : 8'(m));
      chk({14'h0000, rate_mode}, (m == 3) ? 16'h0000 : 16'(m));
    end
    seed = xs(seed);
    wr(`BSR_ADDR_CONTROL, {5'h00, seed[2:0]});
    chk({13'h0000, pa_level}, {13'h0000, seed[2:0]});
    // Buffer filled with spreader off; one byte too many is dropped
    for (int i = 0; i < 33; i++)
      wr(`BSR_ADDR_TX_DATA, 8'(i));
    chk({15'h0000, tx_fifo_ready}, 16'h0000);
    rdchk(`BSR_ADDR_TX_STATUS, 8'h00);
    #1 rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({15'h0000, tx_fifo_ready}, 16'h0001);
    wr(`BSR_ADDR_CONTROL, 8'h80);
    b0 = seed[15:8];
    b1 = seed[23:16];
    v0 = seed[28:24];
    send_rx(b0);
    rdchk(`BSR_ADDR_RX_DATA, b0);
    send_rx(b1);
    rdchk(`BSR_ADDR_RX_DATA, b1);
    // Carrier too short must not convert
    #1 carrier_above_floor = 1'b1;
    repeat (WAIT_CYC - 5) @(posedge clk_sys);
    #1 carrier_above_floor = 1'b0;
    rdchk(`BSR_ADDR_SIG_STR, 8'h00);
    #1 adc_value = v0;
    carrier_above_floor = 1'b1;
    wait_adc(1'b1);
    wait_adc(1'b0);
    rdchk(`BSR_ADDR_SIG_STR, {3'b001, v0});
    #1 adc_value = ~v0;
    repeat (3 * WAIT_CYC) @(posedge clk_sys);
    rdchk(`BSR_ADDR_SIG_STR, {3'b001, v0});
    #1 carrier_above_floor = 1'b0;
    wr(`BSR_ADDR_CONTROL, 8'h00);
    rdchk(`BSR_ADDR_SIG_STR, {3'b000, v0});
    wr(`BSR_ADDR_CONTROL, 8'h80);
    rdchk(`BSR_ADDR_SIG_STR, {3'b000, v0});
    wr(`BSR_ADDR_CD_FORCE, 8'h80);
    repeat (`BSR_SIGNAL_STRENGTH_RESULT_WAIT_CYC + 1) @(posedge clk_sys);
    rdchk(`BSR_ADDR_SIG_STR, {3'b001, ~v0});
    rdchk(`BSR_ADDR_CD_FORCE, 8'h80);
    wr(`BSR_ADDR_CD_FORCE, 8'h00);
    #1 power_down_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({15'h0000, rx_enable}, 16'h0000);
    #1 power_down_n = 1'b1;
    wr(`BSR_ADDR_CONTROL, 8'h00);
    // Second byte loaded while the first is on air: DDR two bytes, then 32 chips one byte
    for (int j = 0; j < 2; j++)
    begin
      md = (j == 0) ? `BSR_MODE_32_DDR : `BSR_MODE_32;
      wr(`BSR_ADDR_DATA_RATE, {6'h00, md});
      wr(`BSR_ADDR_TX_DATA, b0);
      n = 0;
      fork
        begin
          wr(`BSR_ADDR_CONTROL, 8'h40);
          if (j == 0)
            wr(`BSR_ADDR_TX_DATA, b1);
        end
        for (int k = 0; k < 40000 && (n == 0 || tx_active); k++)
        begin
          @(posedge clk_sys);
          #1 n = n + int'(tx_chip_strobe);
          if (tx_chip_strobe)
            chk({15'h0000, tx_chip}, {15'h0000, exp_chip(md, {b1, b0}, n - 1)});
        end
      join
      chk(n[15:0], 16'(exp_chips(md, 2 - j)));
      wr(`BSR_ADDR_CONTROL, 8'h00);
    end
    // Noise floor: twenty forced readings, the class bounds 10, 11, 28 and 29 first
    wr(`BSR_ADDR_CD_FORCE, 8'h80);
    sum_got = 0;
    sum_exp = 0;
    for (int i = 0; i < 20; i++)
    begin
      seed = xs(seed);
      #1 adc_value = (i < 4) ? 5'(i + 32'h0A + 32'h10 * (i >> 1)) : seed[4:0];
      wr(`BSR_ADDR_CONTROL, 8'h80);
      repeat (WAIT_CYC + 1) @(posedge clk_sys);
      rdchk(`BSR_ADDR_SIG_STR, {3'b001, adc_value});
      chk({14'h0000, sig_class(rdat[4:0])}, {14'h0000, sig_class(adc_value)});
      sum_got = sum_got + int'(rdat[4:0]);
      sum_exp = sum_exp + int'(adc_value);
      wr(`BSR_ADDR_CONTROL, 8'h00);
    end
    wr(`BSR_ADDR_CD_FORCE, 8'h00);
    chk(16'(sum_got / 20), 16'(sum_exp / 20));
    print_verdict();
  end
endmodule
`default_nettype wire
